// *** shared/buckboost_pkg.sv ***
// Constants, register layouts and codes for the buck-boost control register bank.
// Assumes a 250 MHz register clock and 8-bit registers, one per 32-bit bus word.
// Function
// (RQ1) Read-only slot code selects boot-time enable
// (RQ2) Enable source acts only in slot 111
// (RQ3) Upward ramp steps one code every 20us
// (RQ4) Buck-only bit restricts converter mode
// (RQ5) Passive discharge on hard reset or disable
// (RQ6) Slow edge bit triples switch edge times
// (RQ7) Active discharge on hard reset or disable
// (RQ8) Level code is 2.5V plus 50mV steps
// (RQ9) Extra peak current adds 25mA per code
// (RQ10) Nominal peak current in 25mA steps
// (RQ11) Adaptive-off fixes peak, zero valley
// (RQ12) Pretrigger bit selects fast quiescent mode
// (RQ13) Zero-cross comparator off when bit set
// (RQ14) Half switch size bit halves power switch
// (RQ15) Two-bit switching frequency threshold select
// (RQ16) Fast mode may follow control pin 1
// (RQ17) DVS select picks controlling pin pair
// (RQ18) Serial DVS mode carries voltage over pins
// (RQ19) Serial mode: pin0 select, pin1 clock, pin2 data
// (RQ20) Enable is OR of selected pins
// (RQ21) Pin pair levels pick alternate setting
// (RQ22) Readback holds last serial voltage code
// (RQ23) Without DVS regulate to main code
package buckboost_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int RAMP_STEP_NS = 20000;
  localparam int RAMP_CYCLES = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_CNT_W = 16;
  localparam int CODE_W = 6;

  localparam logic [5:0] IDX_ENABLE_CONFIG = 6'h31;
  localparam logic [5:0] IDX_VOLTAGE = 6'h32;
  localparam logic [5:0] IDX_PEAK = 6'h33;
  localparam logic [5:0] IDX_TUNING = 6'h34;
  localparam logic [5:0] IDX_DVS = 6'h35;
  localparam logic [5:0] IDX_ALT0 = 6'h36;
  localparam logic [5:0] IDX_READBACK = 6'h3a;

  localparam logic [7:0] ENABLE_CONFIG_RESET = 8'h01;
  localparam logic [7:0] ENABLE_CONFIG_WMASK = 8'h1f;
  localparam logic [7:0] VOLTAGE_RESET = 8'h14;
  localparam logic [7:0] PEAK_RESET = 8'h00;
  localparam logic [7:0] TUNING_RESET = 8'h00;
  localparam logic [7:0] TUNING_WMASK = 8'hf3;
  localparam logic [7:0] DVS_RESET = 8'h00;
  localparam logic [5:0] ALT_RESET = 6'h00;

  localparam logic [2:0] SLOT_OFF = 3'h0;
  localparam logic [2:0] SLOT_AT_0 = 3'h2;
  localparam logic [2:0] SLOT_AT_25 = 3'h3;
  localparam logic [2:0] SLOT_AT_50 = 3'h4;
  localparam logic [2:0] SLOT_SOFT = 3'h7;

  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_ON = 2'h1;
  localparam logic [1:0] SRC_PINS = 2'h2;

  localparam logic [2:0] BOOT_AT_0 = 3'h1;
  localparam logic [2:0] BOOT_AT_25 = 3'h2;
  localparam logic [2:0] BOOT_AT_50 = 3'h3;
  localparam logic [2:0] BOOT_DONE = 3'h4;

  localparam logic [2:0] DVS_OFF = 3'h0;
  localparam logic [2:0] DVS_PAIR_LAST = 3'h6;
  localparam logic [2:0] DVS_SERIAL = 3'h7;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_e;

  typedef struct packed {
    logic [2:0] slot;
    logic [1:0] source;
    logic ramp_on;
    logic buck_only;
    logic passive_on;
  } enable_config_s;

  typedef struct packed {
    logic slow_edge;
    logic active_on;
    logic [5:0] code;
  } voltage_setting_s;

  typedef struct packed {
    logic [3:0] extra;
    logic [3:0] nominal;
  } peak_current_s;

  typedef struct packed {
    logic adaptive_off;
    logic fast;
    logic zero_cross_off;
    logic half_switch;
    logic [1:0] unused;
    logic [1:0] hf_threshold;
  } tuning_s;

  typedef struct packed {
    logic fast_from_pin;
    logic [2:0] dvs_sel;
    logic [3:0] pin_sel;
  } dvs_control_s;

  typedef struct packed {
    logic regulator_enable;
    logic buck_only;
    logic passive_discharge;
    logic active_discharge;
    logic slow_edge;
    logic [5:0] level_code;
    logic [3:0] peak_nominal;
    logic [3:0] peak_extra;
    logic adaptive_peak_off;
    logic fast_mode;
    logic zero_cross_off;
    logic half_switch;
    logic [1:0] hf_threshold;
  } regulator_ctrl_s;

  function automatic logic [7:0] byte_addr(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// *** rtl/serial_dvs_receiver.sv ***
// Serial voltage receiver on the control pins: select low frames, clock rising samples.
// Assumes the pins are already synchronous to i_mclk and sclk is far slower than it.
module serial_dvs_receiver #(
  parameter int CODE_W = buckboost_pkg::CODE_W
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic [CODE_W-1:0] o_code
);

  if (CODE_W < 2 || CODE_W > 15) begin : g_bad_width
    $error("CODE_W out of range");
  end

  logic sclk_q_reg;
  logic cs_n_q_reg;
  logic [CODE_W-1:0] shift_reg;
  logic [3:0] count_reg;
  logic [CODE_W-1:0] code_reg;
  wire logic sclk_rise = i_sclk && !sclk_q_reg;
  wire logic cs_rise = i_cs_n && !cs_n_q_reg;
  wire logic frame_ok = count_reg >= 4'(CODE_W);

  // The last CODE_W bits before select rises form the code, MSB first.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sclk_q_reg <= 1'b0;
      cs_n_q_reg <= 1'b1;
      shift_reg <= '0;
      count_reg <= 4'h0;
      code_reg <= '0;
    end else begin
      sclk_q_reg <= i_sclk;
      cs_n_q_reg <= i_cs_n;
      if (!i_enable) begin
        count_reg <= 4'h0;
      end else if (!i_cs_n && sclk_rise) begin // RQ19
        shift_reg <= {shift_reg[CODE_W-2:0], i_din};
        count_reg <= (count_reg == 4'hf) ? count_reg : count_reg + 4'h1;
      end else if (cs_rise) begin
        count_reg <= 4'h0;
        if (frame_ok) begin
          code_reg <= shift_reg; // RQ22
        end
      end
    end
  end

  assign o_code = code_reg;

  chk_readback_latch: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ22
    (i_enable && cs_rise && frame_ok) |=> (code_reg == $past(shift_reg)))
    else $error("serial readback not latched at frame end");

  chk_short_frame: assert property (@(posedge i_mclk) disable iff (i_rst) // RQ18
    (cs_rise && !frame_ok) |=> $stable(code_reg))
    else $error("short serial frame changed readback");

endmodule // serial_dvs_receiver

// *** rtl/buckboost_control_regs.sv ***
// Buck-boost control register bank with an Avalon-MM slave, enable and voltage logic.
// Assumes strap, boot progress, hard reset and control pins are synchronous to i_mclk.
module buckboost_control_regs #(
  parameter int RAMP_CYCLES = buckboost_pkg::RAMP_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [2:0] i_slot_strap,
  input wire logic [2:0] i_boot_progress,
  input wire logic i_hard_reset,
  input wire logic [3:0] i_control_pins,
  output buckboost_pkg::regulator_ctrl_s o_ctrl
);

  localparam int CNT_W = buckboost_pkg::RAMP_CNT_W;

  if (RAMP_CYCLES < 1 || RAMP_CYCLES >= 2 ** CNT_W) begin : g_bad_ramp
    $error("RAMP_CYCLES out of range");
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  buckboost_pkg::bus_state_e bus_state_reg;
  buckboost_pkg::enable_config_s en_cfg_reg;
  buckboost_pkg::voltage_setting_s vset_reg;
  buckboost_pkg::peak_current_s peak_reg;
  buckboost_pkg::tuning_s tune_reg;
  buckboost_pkg::dvs_control_s dvs_reg;
  buckboost_pkg::regulator_ctrl_s ctrl_reg;
  buckboost_pkg::regulator_ctrl_s ctrl_next;
  logic [5:0] alt_reg [4];
  logic [5:0] level_reg;
  logic [CNT_W-1:0] ramp_cnt_reg;
  logic [31:0] readdata_reg;
  logic [5:0] rx_code;

  // Bus slave: every access is answered with waitrequest low one cycle after it appears.
  wire logic bus_req = i_avs_read || i_avs_write;
  wire logic bus_done = bus_state_reg == buckboost_pkg::BUS_DONE;
  wire logic wr_fire = bus_done && i_avs_write && i_avs_byteenable[0];
  wire logic [7:0] wdata = i_avs_writedata[7:0];

  wire logic sel_en_cfg =
    i_avs_address == buckboost_pkg::byte_addr(buckboost_pkg::IDX_ENABLE_CONFIG);
  wire logic sel_vset = i_avs_address == buckboost_pkg::byte_addr(buckboost_pkg::IDX_VOLTAGE);
  wire logic sel_peak = i_avs_address == buckboost_pkg::byte_addr(buckboost_pkg::IDX_PEAK);
  wire logic sel_tune = i_avs_address == buckboost_pkg::byte_addr(buckboost_pkg::IDX_TUNING);
  wire logic sel_dvs = i_avs_address == buckboost_pkg::byte_addr(buckboost_pkg::IDX_DVS);
  wire logic sel_rdbk = i_avs_address == buckboost_pkg::byte_addr(buckboost_pkg::IDX_READBACK);
  wire logic [5:0] word_idx = i_avs_address[7:2];
  wire logic sel_alt = (i_avs_address[1:0] == 2'b00) && (word_idx >= buckboost_pkg::IDX_ALT0)
    && (word_idx < buckboost_pkg::IDX_ALT0 + 6'h04);
  wire logic [1:0] alt_wsel = i_avs_address[3:2] - buckboost_pkg::IDX_ALT0[1:0];

  // Unmapped addresses read as zero and ignore writes.
  wire logic [7:0] read_mux =
    sel_en_cfg ? en_cfg_reg :
    sel_vset ? vset_reg :
    sel_peak ? peak_reg :
    sel_tune ? (tune_reg & buckboost_pkg::TUNING_WMASK) :
    sel_dvs ? dvs_reg :
    sel_alt ? {2'b00, alt_reg[alt_wsel]} :
    sel_rdbk ? {2'b00, rx_code} : // RQ22
    8'h00;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus_state_reg <= buckboost_pkg::BUS_IDLE;
      readdata_reg <= 32'h0;
    end else begin
      unique case (bus_state_reg)
        buckboost_pkg::BUS_IDLE: begin
          if (bus_req) begin
            bus_state_reg <= buckboost_pkg::BUS_DONE;
            readdata_reg <= {24'h0, read_mux};
          end
        end
        buckboost_pkg::BUS_DONE: begin
          bus_state_reg <= buckboost_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_reg <= buckboost_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign o_avs_waitrequest = !bus_done;
  assign o_avs_readdata = readdata_reg;

  // The slot code is a strap caught while reset is held; software cannot change it.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      en_cfg_reg <= {i_slot_strap, buckboost_pkg::ENABLE_CONFIG_RESET[4:0]}; // RQ1
      vset_reg <= buckboost_pkg::VOLTAGE_RESET;
      peak_reg <= buckboost_pkg::PEAK_RESET;
      tune_reg <= buckboost_pkg::TUNING_RESET;
      dvs_reg <= buckboost_pkg::DVS_RESET;
    end else if (wr_fire) begin
      if (sel_en_cfg) begin
        en_cfg_reg <= (en_cfg_reg & ~buckboost_pkg::ENABLE_CONFIG_WMASK)
          | (wdata & buckboost_pkg::ENABLE_CONFIG_WMASK);
      end
      if (sel_vset) begin
        vset_reg <= wdata;
      end
      if (sel_peak) begin
        peak_reg <= wdata;
      end
      if (sel_tune) begin
        tune_reg <= wdata & buckboost_pkg::TUNING_WMASK;
      end
      if (sel_dvs) begin
        dvs_reg <= wdata;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) begin
        alt_reg[i] <= buckboost_pkg::ALT_RESET;
      end
    end else if (wr_fire && sel_alt) begin
      alt_reg[alt_wsel] <= wdata[5:0];
    end
  end

  // Enable: boot slots follow boot progress, slot 111 hands over to the enable source.
  wire logic [2:0] slot = en_cfg_reg.slot;
  wire logic pin_or = |(i_control_pins & dvs_reg.pin_sel);
  wire logic boot_done = i_boot_progress >= buckboost_pkg::BOOT_DONE;
  wire logic slot_enable =
    (slot == buckboost_pkg::SLOT_AT_0 && i_boot_progress >= buckboost_pkg::BOOT_AT_0) ||
    (slot == buckboost_pkg::SLOT_AT_25 && i_boot_progress >= buckboost_pkg::BOOT_AT_25) ||
    (slot == buckboost_pkg::SLOT_AT_50 && i_boot_progress >= buckboost_pkg::BOOT_AT_50); // RQ1
  wire logic source_enable = (en_cfg_reg.source == buckboost_pkg::SRC_ON) ||
    (en_cfg_reg.source == buckboost_pkg::SRC_PINS && pin_or); // RQ2 RQ20
  wire logic soft_slot = slot == buckboost_pkg::SLOT_SOFT;
  wire logic reg_enable = slot_enable || (soft_slot && boot_done && source_enable);

  // Voltage target: main code, an alternate picked by a pin pair, or the serial code.
  function automatic logic [1:0] pair_levels(input logic [2:0] sel, input logic [3:0] p);
    unique case (sel)
      3'h1: return {p[0], p[1]};
      3'h2: return {p[0], p[2]};
      3'h3: return {p[0], p[3]};
      3'h4: return {p[1], p[2]};
      3'h5: return {p[1], p[3]};
      default: return {p[2], p[3]};
    endcase
  endfunction

  wire logic [2:0] dvs_sel = dvs_reg.dvs_sel;
  wire logic pair_mode = dvs_sel != buckboost_pkg::DVS_OFF
    && dvs_sel <= buckboost_pkg::DVS_PAIR_LAST; // RQ17
  wire logic serial_mode = dvs_sel == buckboost_pkg::DVS_SERIAL; // RQ18 RQ19
  wire logic [1:0] pair_idx = pair_levels(dvs_sel, i_control_pins); // RQ21
  wire logic [5:0] target_code = serial_mode ? rx_code :
    pair_mode ? alt_reg[pair_idx] : vset_reg.code; // RQ23

  serial_dvs_receiver #(
    .CODE_W(buckboost_pkg::CODE_W)
  ) u_serial_rx (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_enable(serial_mode),
    .i_cs_n(i_control_pins[0]),
    .i_sclk(i_control_pins[1]),
    .i_din(i_control_pins[2]),
    .o_code(rx_code)
  );

  // Upward moves with ramping step one code per interval; all others apply at once.
  wire logic ramp_up = en_cfg_reg.ramp_on && (target_code > level_reg);
  wire logic ramp_due = ramp_cnt_reg == CNT_W'(RAMP_CYCLES - 1);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      level_reg <= buckboost_pkg::VOLTAGE_RESET[5:0];
      ramp_cnt_reg <= '0;
    end else if (ramp_up) begin
      if (ramp_due) begin
        level_reg <= level_reg + 6'h01; // RQ3
        ramp_cnt_reg <= '0;
      end else begin
        ramp_cnt_reg <= ramp_cnt_reg + CNT_W'(1);
      end
    end else begin
      level_reg <= target_code; // RQ3 RQ23
      ramp_cnt_reg <= '0;
    end
  end

  // Outputs to the analog core are registered.
  wire logic fast_now = dvs_reg.fast_from_pin ? i_control_pins[1] : tune_reg.fast; // RQ12 RQ16
  wire logic passive_now = i_hard_reset || (en_cfg_reg.passive_on && !reg_enable); // RQ5
  wire logic active_now = i_hard_reset || (vset_reg.active_on && !reg_enable); // RQ7

  assign ctrl_next = '{
    regulator_enable: reg_enable,
    buck_only: en_cfg_reg.buck_only, // RQ4
    passive_discharge: passive_now,
    active_discharge: active_now,
    slow_edge: vset_reg.slow_edge, // RQ6
    level_code: level_reg, // RQ8
    peak_nominal: peak_reg.nominal, // RQ10
    peak_extra: peak_reg.extra, // RQ9
    adaptive_peak_off: tune_reg.adaptive_off, // RQ11
    fast_mode: fast_now,
    zero_cross_off: tune_reg.zero_cross_off, // RQ13
    half_switch: tune_reg.half_switch, // RQ14
    hf_threshold: tune_reg.hf_threshold // RQ15
  };

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign o_ctrl = ctrl_reg;

  chk_bus_answer: assert property (
    (bus_req && !bus_done) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one cycle after request");

  chk_slot_off: assert property ( // RQ1
    (slot == buckboost_pkg::SLOT_OFF) |=> !o_ctrl.regulator_enable)
    else $error("disabled slot drove enable");

  chk_slot_boot: assert property ( // RQ1
    (slot == buckboost_pkg::SLOT_AT_25 && i_boot_progress < buckboost_pkg::BOOT_AT_25)
    |=> !o_ctrl.regulator_enable)
    else $error("slot enabled before its boot point");

  chk_source_on: assert property ( // RQ2
    (soft_slot && boot_done && en_cfg_reg.source == buckboost_pkg::SRC_ON)
    |=> o_ctrl.regulator_enable)
    else $error("enable source on did not enable");

  chk_source_off: assert property ( // RQ2
    (soft_slot && en_cfg_reg.source == buckboost_pkg::SRC_OFF) |=> !o_ctrl.regulator_enable)
    else $error("enable source off did not disable");

  chk_pin_or: assert property ( // RQ20
    (soft_slot && boot_done && en_cfg_reg.source == buckboost_pkg::SRC_PINS)
    |=> (o_ctrl.regulator_enable == $past(pin_or)))
    else $error("pin enable is not the OR of selected pins");

  chk_ramp_step: assert property ( // RQ3
    ($past(en_cfg_reg.ramp_on) && level_reg > $past(level_reg))
    |-> (level_reg == $past(level_reg) + 6'h01))
    else $error("ramped rise skipped a code");

  chk_ramp_hold: assert property ( // RQ3
    (RAMP_CYCLES > 2 && ramp_up && ramp_cnt_reg == '0) |=> $stable(level_reg) [*2])
    else $error("ramp stepped before its interval");

  chk_down_direct: assert property ( // RQ3
    (target_code < level_reg) |=> (level_reg == $past(target_code)))
    else $error("downward change not applied at once");

  chk_psv_hard: assert property ( // RQ5
    i_hard_reset |=> (o_ctrl.passive_discharge && o_ctrl.active_discharge))
    else $error("hard reset did not discharge");

  chk_act_idle: assert property ( // RQ7
    (!vset_reg.active_on && !i_hard_reset) |=> !o_ctrl.active_discharge)
    else $error("active discharge without cause");

  chk_fast_pin: assert property ( // RQ16
    (dvs_reg.fast_from_pin) |=> (o_ctrl.fast_mode == $past(i_control_pins[1])))
    else $error("fast mode did not follow pin 1");

  chk_pair_pick: assert property ( // RQ21
    (dvs_sel == 3'h1 && i_control_pins[1:0] == 2'b01) |-> (target_code == alt_reg[2]))
    else $error("pin pair picked wrong alternate");

  chk_main_code: assert property ( // RQ23
    (dvs_sel == buckboost_pkg::DVS_OFF && !en_cfg_reg.ramp_on)
    |=> (level_reg == $past(vset_reg.code)))
    else $error("main code not applied without DVS");

endmodule // buckboost_control_regs

// *** verification/control_pin_host.sv ***
// Host model that drives the four control pins, including serial voltage frames.
// Assumes one bench process calls its tasks, each entered just after a rising i_mclk edge.
module control_pin_host (
  input wire logic i_mclk,
  output logic [3:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_pins = 4'h1;

  task automatic set_pins(input logic [3:0] v);
    @(posedge i_mclk);
    o_pins <= v;
  endtask

  // The serial clock is held high for two edges and low for three between bits, data is set while the clock is low.
  task automatic send_code(input logic [5:0] code, input int nbits);
    for (int i = nbits - 1; i >= 0; i--) begin
      @(posedge i_mclk);
      o_pins <= {1'b0, code[i], 2'b00};
      repeat (2) @(posedge i_mclk);
      o_pins[1] <= 1'b1;
      repeat (2) @(posedge i_mclk);
      o_pins[1] <= 1'b0;
    end
    @(posedge i_mclk);
    o_pins <= {1'b0, ~code[0], 2'b01};
  endtask
endmodule // control_pin_host

// *** verification/buckboost_control_regs_bench.sv ***
// Self-checking bench for the buck-boost control register bank.
// Assumes the design answers each Avalon request after one wait cycle.
module buckboost_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RAMP = 8;
  logic i_mclk, i_rst, rd, wr, waitreq, hard;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [3:0] be, pins;
  logic [2:0] strap, prog;
  buckboost_pkg::regulator_ctrl_s ctrl;
  wire logic [7:0] tuning_seen = {2'b00, ctrl.adaptive_peak_off, ctrl.fast_mode,
    ctrl.zero_cross_off, ctrl.half_switch, ctrl.hf_threshold};
  int n_errors, samples_checked, cycles;
  int pa[6] = '{0, 0, 0, 1, 1, 2};
  int pb[6] = '{1, 2, 3, 2, 3, 3};
  logic [2:0] straps[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [7:0] rst_addr[7] = '{8'hc8, 8'hcc, 8'hd0, 8'hd4, 8'hd8, 8'he8, 8'hfc};
  logic [7:0] rst_val[7] = '{8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  buckboost_control_regs #(.RAMP_CYCLES(RAMP)) u_buckboost_control_regs (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_slot_strap(strap),
    .i_boot_progress(prog), .i_hard_reset(hard), .i_control_pins(pins), .o_ctrl(ctrl)
  );
  control_pin_host u_control_pin_host (.i_mclk(i_mclk), .o_pins(pins));

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic ck(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request rises after an edge and is held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] e);
    @(posedge i_mclk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    be <= e;
    @(posedge i_mclk);
    while (waitreq !== 1'b0) @(posedge i_mclk);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    ck($sformatf("reg %h", a), exp, got[7:0]);
    ck("readdata upper", 8'h00, got[31:24] | got[23:16] | got[15:8]);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(posedge i_mclk);
    strap <= s;
    i_rst <= 1'b1;
    tick(10);
    i_rst <= 1'b0;
  endtask

  initial begin
    logic exp_en;
    i_rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    be = 4'h0;
    strap = 3'h0;
    prog = 3'h0;
    hard = 1'b0;
    for (int s = 0; s < 6; s++) begin
      prog <= 3'h0;
      do_reset(straps[s]);
      rd_chk(8'hc4, {straps[s], 5'h01});
      for (int p = 0; p < 5; p++) begin
        prog <= p[2:0];
        tick(4);
        exp_en = (straps[s] == 3'h2 && p >= 1) || (straps[s] == 3'h3 && p >= 2) ||
          (straps[s] == 3'h4 && p >= 3);
        ck("slot enable", exp_en, ctrl.regulator_enable);
        ck("passive", !exp_en, ctrl.passive_discharge);
      end
    end
    for (int i = 0; i < 7; i++) rd_chk(rst_addr[i], rst_val[i]);
    wr_reg(8'hc4, 8'h08);
    rd_chk(8'hc4, 8'he8);
    tick(3);
    ck("source on", 1'b1, ctrl.regulator_enable);
    ck("passive off", 1'b0, ctrl.passive_discharge);
    wr_reg(8'hc4, 8'h18);
    tick(3);
    ck("source reserved", 1'b0, ctrl.regulator_enable);
    wr_reg(8'hc4, 8'h10);
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'hd4, s == 0 ? 8'h05 : 8'h0a);
      for (int p = 0; p < 16; p++) begin
        u_control_pin_host.set_pins(p[3:0]);
        tick(4);
        ck("pin or", |(p[3:0] & (s == 0 ? 4'h5 : 4'ha)), ctrl.regulator_enable);
      end
    end
    wr_reg(8'hc4, 8'h01);
    wr_reg(8'hc8, 8'h54);
    tick(3);
    ck("active low en", 1'b1, ctrl.active_discharge);
    wr_reg(8'hc4, 8'h08);
    wr_reg(8'hc8, 8'ha0);
    hard <= 1'b1;
    tick(4);
    ck("hard passive", 1'b1, ctrl.passive_discharge);
    ck("hard active", 1'b1, ctrl.active_discharge);
    ck("slow edge", 1'b1, ctrl.slow_edge);
    ck("direct level", 8'h20, ctrl.level_code);
    hard <= 1'b0;
    wr_reg(8'hcc, 8'h5a);
    wr_reg(8'hd0, 8'hff);
    bus(1'b1, 8'hd0, 8'h00, 4'h0);
    rd_chk(8'hd0, 8'hf3);
    tick(2);
    ck("extra", 8'h05, ctrl.peak_extra);
    ck("nominal", 8'h0a, ctrl.peak_nominal);
    ck("tuning", 8'h3f, tuning_seen);
    wr_reg(8'hc4, 8'h0a);
    for (int h = 0; h < 4; h++) begin
      wr_reg(8'hd0, {6'h00, h[1:0]});
      tick(3);
      ck("hf threshold", {6'h00, h[1:0]}, tuning_seen);
      ck("buck only", 1'b1, ctrl.buck_only);
    end
    wr_reg(8'hd4, 8'h80);
    for (int p = 0; p < 2; p++) begin
      u_control_pin_host.set_pins({2'b00, p[0], 1'b0});
      tick(4);
      ck("fast pin", p[0], ctrl.fast_mode);
    end
    u_control_pin_host.set_pins(4'h0);
    wr_reg(8'hd0, 8'h40);
    tick(3);
    ck("fast pin over bit", 1'b0, ctrl.fast_mode);
    wr_reg(8'hc4, 8'h0c);
    wr_reg(8'hc8, 8'h10);
    tick(4);
    ck("ramp down direct", 8'h10, ctrl.level_code);
    wr_reg(8'hc8, 8'h13);
    tick(4);
    ck("ramp first", 8'h10, ctrl.level_code);
    tick(3 * RAMP + 2);
    ck("ramp end", 8'h13, ctrl.level_code);
    wr_reg(8'hc4, 8'h08);
    for (int a = 0; a < 4; a++) wr_reg(8'hd8 + 8'(4 * a), 8'h21 + 8'(a));
    for (int s = 0; s < 6; s++) begin
      wr_reg(8'hd4, {1'b0, 3'(s + 1), 4'h0});
      for (int lv = 0; lv < 4; lv++) begin
        u_control_pin_host.set_pins(4'((lv / 2) << pa[s]) | 4'((lv % 2) << pb[s]));
        tick(5);
        ck("pair level", 8'h21 + 8'(lv), ctrl.level_code);
      end
    end
    wr_reg(8'hd4, 8'h70);
    u_control_pin_host.set_pins(4'h1);
    u_control_pin_host.send_code(6'h2d, 6);
    tick(5);
    rd_chk(8'he8, 8'h2d);
    ck("serial level", 8'h2d, ctrl.level_code);
    u_control_pin_host.send_code(6'h05, 4);
    tick(5);
    rd_chk(8'he8, 8'h2d);
    summarize();
  end
endmodule // buckboost_control_regs_bench
